// ==== src/sensor_irq_and_ident_regs.sv ====
`timescale 1ns/1ns
// Functional notes
// - Set status-nonzero flag bit 6 when any status register becomes nonzero.
// - Set command-done flag bit 5 when a host command finishes handling.
// - Set histogram-ready flag bit 3 when raw histogram data is available.
// - Set result-ready flag bit 1 when a measurement result is available.
// - Drive interrupt pin low while any enabled flag is set.
// - Writing one clears that flag only; writing zero leaves it unchanged.
// - Events arriving during a clear are kept; set beats clear.
// - Enable bits at 0xE2 are read-write, one enables, reset to zero.
// - Identity register shows fixed chip id in bits 5:0.
// - Revision register shows chip revision in bits 2:0.
// - Patch and build revisions read-only at 0x02 and 0x03, reset zero.
// - Application registers mapped only while application id equals 0x03.
// - Registers at 0xE0 and above usable only once processor ready.
module sensor_irq_and_ident_regs (
  input  wire logic                       mclk_in,        // 50 MHz clock
  input  wire logic                       reset_n_in,     // Sync reset, active low
  input  wire sensor_irq_pkg::reg_req_t   req_in,         // Register access request
  input  wire sensor_irq_pkg::event_t     event_in,       // One-cycle event pulses
  input  wire logic [7:0]                 patch_rev_in,   // Firmware patch revision
  input  wire logic [7:0]                 build_rev_in,   // Firmware build revision
  input  wire logic [7:0]                 app_id_in,      // Selected application id
  input  wire logic                       cpu_ready_in,   // Processor ready
  output logic [7:0]                      rdata_out,      // Read data, next cycle
  output logic                            rvalid_out,     // Read data valid pulse
  output logic                            int_n_out       // Interrupt, active low
);
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] patch_rev;
  logic [7:0] build_rev;

  wire logic       high_ok   = cpu_ready_in;
  wire logic       app_ok    = (app_id_in == sensor_irq_pkg::APP_MEASURE);
  wire logic       is_high   = (req_in.addr >= sensor_irq_pkg::OFS_HIGH_BASE);
  wire logic       sel_flags = req_in.wr && high_ok
                               && (req_in.addr == sensor_irq_pkg::OFS_FLAGS);
  wire logic       sel_enab  = req_in.wr && high_ok
                               && (req_in.addr == sensor_irq_pkg::OFS_ENABLES);
  wire logic [7:0] set_vec   = {1'b0, event_in.status_nonzero, event_in.command_done, 1'b0,
                                event_in.histogram_ready, 1'b0, event_in.result_ready, 1'b0};
  wire logic [7:0] clr_vec   = sel_flags ? (req_in.wdata & sensor_irq_pkg::EVENT_MASK)
                                         : sensor_irq_pkg::ZERO_BYTE;
  // Set wins over a simultaneous clear
  wire logic [7:0] next_flags = ((flags & ~clr_vec) | set_vec)
                                & sensor_irq_pkg::EVENT_MASK;
  wire logic [7:0] next_enables = sel_enab ? (req_in.wdata & sensor_irq_pkg::EVENT_MASK)
                                           : enables;
  wire logic       next_int_n = ~|(next_flags & next_enables);
  wire logic [7:0] ident_word = {2'b00, sensor_irq_pkg::CHIP_ID_DEFAULT};
  wire logic [7:0] rev_word   = {5'b00000, sensor_irq_pkg::CHIP_REV_DEFAULT};

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = sensor_irq_pkg::ZERO_BYTE;
    if (is_high && high_ok) begin
      unique case (req_in.addr)
        sensor_irq_pkg::OFS_FLAGS:    next_rdata = flags;
        sensor_irq_pkg::OFS_ENABLES:  next_rdata = enables;
        sensor_irq_pkg::OFS_IDENTITY: next_rdata = ident_word;
        sensor_irq_pkg::OFS_REVISION: next_rdata = rev_word;
        default:                      next_rdata = sensor_irq_pkg::ZERO_BYTE;
      endcase
    end else if (!is_high && app_ok) begin
      unique case (req_in.addr)
        sensor_irq_pkg::OFS_PATCH_REV: next_rdata = patch_rev;
        sensor_irq_pkg::OFS_BUILD_REV: next_rdata = build_rev;
        default:                       next_rdata = sensor_irq_pkg::ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      flags      <= sensor_irq_pkg::ZERO_BYTE;
      enables    <= sensor_irq_pkg::ZERO_BYTE;
      patch_rev  <= sensor_irq_pkg::ZERO_BYTE;
      build_rev  <= sensor_irq_pkg::ZERO_BYTE;
      rdata_out  <= sensor_irq_pkg::ZERO_BYTE;
      rvalid_out <= 1'b0;
      int_n_out  <= 1'b1;
    end else begin
      flags      <= next_flags;
      enables    <= next_enables;
      patch_rev  <= patch_rev_in;
      build_rev  <= build_rev_in;
      rdata_out  <= next_rdata;
      rvalid_out <= req_in.rd;
      int_n_out  <= next_int_n;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  // Clearing writes with no competing event on the same bit
  sequence s_clear_write;
    sel_flags && req_in.wdata[sensor_irq_pkg::BIT_CMD_DONE] && !event_in.command_done;
  endsequence

  sequence s_clear_status;
    sel_flags && req_in.wdata[sensor_irq_pkg::BIT_STATUS_NZ] && !event_in.status_nonzero;
  endsequence

  sequence s_clear_hist;
    sel_flags && req_in.wdata[sensor_irq_pkg::BIT_HIST_RDY] && !event_in.histogram_ready;
  endsequence

  sequence s_clear_result;
    sel_flags && req_in.wdata[sensor_irq_pkg::BIT_RESULT_RDY] && !event_in.result_ready;
  endsequence

  // Clearing writes that meet a new event on the same bit
  sequence s_race_status;
    sel_flags && req_in.wdata[sensor_irq_pkg::BIT_STATUS_NZ] && event_in.status_nonzero;
  endsequence

  sequence s_race_cmd;
    sel_flags && req_in.wdata[sensor_irq_pkg::BIT_CMD_DONE] && event_in.command_done;
  endsequence

  sequence s_race_hist;
    sel_flags && req_in.wdata[sensor_irq_pkg::BIT_HIST_RDY] && event_in.histogram_ready;
  endsequence

  sequence s_race_result;
    sel_flags && req_in.wdata[sensor_irq_pkg::BIT_RESULT_RDY] && event_in.result_ready;
  endsequence

  // Reads of the individual registers
  sequence s_rd_flags;
    req_in.rd && high_ok && (req_in.addr == sensor_irq_pkg::OFS_FLAGS);
  endsequence

  sequence s_rd_enables;
    req_in.rd && high_ok && (req_in.addr == sensor_irq_pkg::OFS_ENABLES);
  endsequence

  sequence s_rd_revision;
    req_in.rd && high_ok && (req_in.addr == sensor_irq_pkg::OFS_REVISION);
  endsequence

  sequence s_rd_patch;
    req_in.rd && app_ok && (req_in.addr == sensor_irq_pkg::OFS_PATCH_REV);
  endsequence

  sequence s_rd_build;
    req_in.rd && app_ok && (req_in.addr == sensor_irq_pkg::OFS_BUILD_REV);
  endsequence

  sequence s_rd_high_unmapped;
    req_in.rd && is_high
    && (req_in.addr != sensor_irq_pkg::OFS_FLAGS)
    && (req_in.addr != sensor_irq_pkg::OFS_ENABLES)
    && (req_in.addr != sensor_irq_pkg::OFS_IDENTITY)
    && (req_in.addr != sensor_irq_pkg::OFS_REVISION);
  endsequence

  sequence s_rd_low_unmapped;
    req_in.rd && !is_high
    && (req_in.addr != sensor_irq_pkg::OFS_PATCH_REV)
    && (req_in.addr != sensor_irq_pkg::OFS_BUILD_REV);
  endsequence

  // Writes to the high region while the processor is not ready
  sequence s_wr_enables_locked;
    req_in.wr && !high_ok && (req_in.addr == sensor_irq_pkg::OFS_ENABLES);
  endsequence

  sequence s_wr_flags_locked;
    req_in.wr && !high_ok && (req_in.addr == sensor_irq_pkg::OFS_FLAGS)
    && (set_vec == sensor_irq_pkg::ZERO_BYTE);
  endsequence

  // Event capture
  AST_STATUS_SET: assert property (
    event_in.status_nonzero |=> flags[sensor_irq_pkg::BIT_STATUS_NZ])
    else $error("status flag not set");
  AST_CMD_SET: assert property (
    event_in.command_done |=> flags[sensor_irq_pkg::BIT_CMD_DONE])
    else $error("command flag not set");
  AST_HIST_SET: assert property (
    event_in.histogram_ready |=> flags[sensor_irq_pkg::BIT_HIST_RDY])
    else $error("histogram flag not set");
  AST_RESULT_SET: assert property (
    event_in.result_ready |=> flags[sensor_irq_pkg::BIT_RESULT_RDY])
    else $error("result flag not set");

  // Interrupt pin follows the registered flags and enables
  AST_PIN_LOW: assert property (
    int_n_out == ~|(flags & enables))
    else $error("interrupt pin wrong");
  AST_PIN_RELEASE: assert property (
    (flags & enables) == sensor_irq_pkg::ZERO_BYTE |-> int_n_out)
    else $error("interrupt pin not released");
  AST_PIN_STATUS: assert property (
    flags[sensor_irq_pkg::BIT_STATUS_NZ] && enables[sensor_irq_pkg::BIT_STATUS_NZ] |-> !int_n_out)
    else $error("status interrupt missing");
  AST_PIN_CMD: assert property (
    flags[sensor_irq_pkg::BIT_CMD_DONE] && enables[sensor_irq_pkg::BIT_CMD_DONE] |-> !int_n_out)
    else $error("command interrupt missing");
  AST_PIN_HIST: assert property (
    flags[sensor_irq_pkg::BIT_HIST_RDY] && enables[sensor_irq_pkg::BIT_HIST_RDY] |-> !int_n_out)
    else $error("histogram interrupt missing");
  AST_PIN_RESULT: assert property (
    flags[sensor_irq_pkg::BIT_RESULT_RDY] && enables[sensor_irq_pkg::BIT_RESULT_RDY]
    |-> !int_n_out)
    else $error("result interrupt missing");

  // Write-one-to-clear, bit by bit
  AST_W1C: assert property (
    s_clear_write |=> !flags[sensor_irq_pkg::BIT_CMD_DONE])
    else $error("flag not cleared");
  AST_W1C_STATUS: assert property (
    s_clear_status |=> !flags[sensor_irq_pkg::BIT_STATUS_NZ])
    else $error("status flag not cleared");
  AST_W1C_HIST: assert property (
    s_clear_hist |=> !flags[sensor_irq_pkg::BIT_HIST_RDY])
    else $error("histogram flag not cleared");
  AST_W1C_RESULT: assert property (
    s_clear_result |=> !flags[sensor_irq_pkg::BIT_RESULT_RDY])
    else $error("result flag not cleared");
  AST_ZERO_WRITE: assert property (
    sel_flags && ((req_in.wdata & sensor_irq_pkg::EVENT_MASK) == sensor_irq_pkg::ZERO_BYTE)
    |=> (flags & $past(flags)) == $past(flags))
    else $error("zero write cleared a flag");

  // No event is lost while a clear is in progress
  AST_SET_WINS_STATUS: assert property (
    s_race_status |=> flags[sensor_irq_pkg::BIT_STATUS_NZ])
    else $error("status event lost");
  AST_SET_WINS_CMD: assert property (
    s_race_cmd |=> flags[sensor_irq_pkg::BIT_CMD_DONE])
    else $error("command event lost");
  AST_SET_WINS_HIST: assert property (
    s_race_hist |=> flags[sensor_irq_pkg::BIT_HIST_RDY])
    else $error("histogram event lost");
  AST_SET_WINS_RESULT: assert property (
    s_race_result |=> flags[sensor_irq_pkg::BIT_RESULT_RDY])
    else $error("result event lost");

  // Flags stay set until the host clears them
  AST_HOLD: assert property (
    flags[sensor_irq_pkg::BIT_HIST_RDY]
    && !(sel_flags && req_in.wdata[sensor_irq_pkg::BIT_HIST_RDY])
    |=> flags[sensor_irq_pkg::BIT_HIST_RDY])
    else $error("flag lost");
  AST_HOLD_STATUS: assert property (
    flags[sensor_irq_pkg::BIT_STATUS_NZ]
    && !(sel_flags && req_in.wdata[sensor_irq_pkg::BIT_STATUS_NZ])
    |=> flags[sensor_irq_pkg::BIT_STATUS_NZ])
    else $error("status flag lost");
  AST_HOLD_CMD: assert property (
    flags[sensor_irq_pkg::BIT_CMD_DONE]
    && !(sel_flags && req_in.wdata[sensor_irq_pkg::BIT_CMD_DONE])
    |=> flags[sensor_irq_pkg::BIT_CMD_DONE])
    else $error("command flag lost");
  AST_HOLD_RESULT: assert property (
    flags[sensor_irq_pkg::BIT_RESULT_RDY]
    && !(sel_flags && req_in.wdata[sensor_irq_pkg::BIT_RESULT_RDY])
    |=> flags[sensor_irq_pkg::BIT_RESULT_RDY])
    else $error("result flag lost");

  // Reserved bits and enables
  AST_RESERVED: assert property (
    (flags & ~sensor_irq_pkg::EVENT_MASK) == sensor_irq_pkg::ZERO_BYTE
    && (enables & ~sensor_irq_pkg::EVENT_MASK) == sensor_irq_pkg::ZERO_BYTE)
    else $error("reserved bit set");
  AST_ENABLE_WR: assert property (
    sel_enab |=> enables == ($past(req_in.wdata) & sensor_irq_pkg::EVENT_MASK))
    else $error("enable not written");
  AST_ENABLE_KEEP: assert property (
    !sel_enab |=> enables == $past(enables))
    else $error("enable changed without write");

  // Read path
  AST_RVALID_SET: assert property (
    req_in.rd |=> rvalid_out)
    else $error("read valid missing");
  AST_RVALID_CLR: assert property (
    !req_in.rd |=> !rvalid_out)
    else $error("read valid spurious");
  AST_RD_FLAGS: assert property (
    s_rd_flags |=> rdata_out == $past(flags))
    else $error("flag read wrong");
  AST_RD_ENABLES: assert property (
    s_rd_enables |=> rdata_out == $past(enables))
    else $error("enable read wrong");
  AST_IDENT: assert property (
    req_in.rd && high_ok && req_in.addr == sensor_irq_pkg::OFS_IDENTITY
    |=> (rdata_out & sensor_irq_pkg::IDENT_MASK) == {2'b00, sensor_irq_pkg::CHIP_ID_DEFAULT})
    else $error("identity wrong");
  AST_REVISION: assert property (
    s_rd_revision
    |=> (rdata_out & sensor_irq_pkg::REV_MASK) == {5'b00000, sensor_irq_pkg::CHIP_REV_DEFAULT})
    else $error("revision wrong");
  AST_PATCH: assert property (
    s_rd_patch |=> rdata_out == $past(patch_rev))
    else $error("patch revision wrong");
  AST_BUILD: assert property (
    s_rd_build |=> rdata_out == $past(build_rev))
    else $error("build revision wrong");
  AST_HIGH_UNMAPPED: assert property (
    s_rd_high_unmapped |=> rdata_out == sensor_irq_pkg::ZERO_BYTE)
    else $error("unmapped high register visible");
  AST_LOW_UNMAPPED: assert property (
    s_rd_low_unmapped |=> rdata_out == sensor_irq_pkg::ZERO_BYTE)
    else $error("unmapped low register visible");

  // Access gating
  AST_APP_GATE: assert property (
    req_in.rd && !app_ok && !is_high |=> rdata_out == sensor_irq_pkg::ZERO_BYTE)
    else $error("app register visible");
  AST_READY_GATE: assert property (
    req_in.rd && !high_ok && is_high |=> rdata_out == sensor_irq_pkg::ZERO_BYTE)
    else $error("high register visible");
  AST_LOCKED_ENAB: assert property (
    s_wr_enables_locked |=> enables == $past(enables))
    else $error("enable written while locked");
  AST_LOCKED_FLAGS: assert property (
    s_wr_flags_locked |=> flags == $past(flags))
    else $error("flags cleared while locked");

  // Reset state, checked while reset is applied
  AST_RESET_STATE: assert property (disable iff (1'b0)
    !reset_n_in |=> flags == sensor_irq_pkg::ZERO_BYTE && enables == sensor_irq_pkg::ZERO_BYTE)
    else $error("register reset wrong");
  AST_RESET_OUTS: assert property (disable iff (1'b0)
    !reset_n_in |=> int_n_out && !rvalid_out && rdata_out == sensor_irq_pkg::ZERO_BYTE)
    else $error("output reset wrong");
  AST_RESET_REVS: assert property (disable iff (1'b0)
    !reset_n_in
    |=> patch_rev == sensor_irq_pkg::ZERO_BYTE && build_rev == sensor_irq_pkg::ZERO_BYTE)
    else $error("revision reset wrong");

endmodule // sensor_irq_and_ident_regs

// ==== src/sensor_irq_pkg.sv ====
package sensor_irq_pkg;
  localparam logic [7:0] OFS_PATCH_REV  = 8'h02;
  localparam logic [7:0] OFS_BUILD_REV  = 8'h03;
  localparam logic [7:0] OFS_FLAGS      = 8'hE1;
  localparam logic [7:0] OFS_ENABLES    = 8'hE2;
  localparam logic [7:0] OFS_IDENTITY   = 8'hE3;
  localparam logic [7:0] OFS_REVISION   = 8'hE4;
  localparam logic [7:0] OFS_HIGH_BASE  = 8'hE0;
  localparam logic [7:0] APP_MEASURE    = 8'h03;
  localparam int         BIT_STATUS_NZ  = 6;
  localparam int         BIT_CMD_DONE   = 5;
  localparam int         BIT_HIST_RDY   = 3;
  localparam int         BIT_RESULT_RDY = 1;
  localparam logic [7:0] EVENT_MASK     = 8'h6A;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
  localparam logic [7:0] IDENT_MASK     = 8'h3F;
  localparam logic [7:0] REV_MASK       = 8'h07;
  // Chip identifier value is arbitrary
  localparam logic [5:0] CHIP_ID_DEFAULT  = 6'h15;
  // Chip revision value is arbitrary
  localparam logic [2:0] CHIP_REV_DEFAULT = 3'h1;

  typedef struct packed {
    logic       status_nonzero;
    logic       command_done;
    logic       histogram_ready;
    logic       result_ready;
  } event_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ==== test/host_model.sv ====
`timescale 1ns/1ns
module host_model (
  output sensor_irq_pkg::reg_req_t req_out  // Register request
);
  initial req_out = '0;
  task automatic issue(input logic w, r, input logic [7:0] a, d);
    req_out <= '{wr: w, rd: r, addr: a, wdata: d & sensor_irq_pkg::EVENT_MASK};
  endtask
endmodule  // host_model

// ==== test/test_sensor_irq_and_ident_regs.sv ====
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module test_sensor_irq_and_ident_regs;
  logic mclk_in = 0, reset_n_in = 0, cpu_ready = 0, rvalid, int_n, xv, xi;
  logic [7:0] app_id = 8'h03, rdata, flg, en, xr, xm;
  sensor_irq_pkg::event_t   ev = '0;
  sensor_irq_pkg::reg_req_t req;
  int fails = 0, num_checks = 0, cyc = 0;
  localparam logic [7:0] ADDRS [8] = '{8'h02, 8'h03, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'h05, 8'hF0};
  initial forever #10 mclk_in = ~mclk_in;
  host_model u_host_model (.req_out(req));
  sensor_irq_and_ident_regs u_sensor_irq_and_ident_regs (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .req_in(req), .event_in(ev), .patch_rev_in(8'hA5),
    .build_rev_in(8'h3C), .app_id_in(app_id), .cpu_ready_in(cpu_ready), .rdata_out(rdata),
    .rvalid_out(rvalid), .int_n_out(int_n));
  function automatic logic [7:0] exp_read(input logic [7:0] a);
    if (a >= 8'hE0 && !cpu_ready) return 8'h00;
    case (a)
      8'h02: return (app_id == 8'h03) ? 8'hA5 : 8'h00;
      8'h03: return (app_id == 8'h03) ? 8'h3C : 8'h00;
      8'hE1: return flg;
      8'hE2: return en;
      8'hE3: return {2'h0, sensor_irq_pkg::CHIP_ID_DEFAULT};
      8'hE4: return {5'h00, sensor_irq_pkg::CHIP_REV_DEFAULT};
      default: return 8'h00;
    endcase
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic step(input logic w, r, input logic [7:0] a, d, input logic [3:0] e,
                      input logic c, input logic [7:0] p);
    @(posedge mclk_in);
    u_host_model.issue(w, r, a, d);
    ev <= e;
    cpu_ready <= c;
    app_id <= p;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
    xv = reset_n_in & req.rd;
    xr = reset_n_in ? exp_read(req.addr) : 8'h00;
    xm = (req.addr == 8'hE3) ? 8'h3F : (req.addr == 8'hE4) ? 8'h07 : 8'hFF;
    if (!reset_n_in) {flg, en} = 16'h0000;
    else begin
      if (req.wr && cpu_ready && req.addr == 8'hE1) flg = flg & ~req.wdata;
      if (req.wr && cpu_ready && req.addr == 8'hE2) en = req.wdata;
      flg = flg | {1'b0, ev[3], ev[2], 1'b0, ev[1], 1'b0, ev[0], 1'b0};
    end
    xi = ~|(flg & en);
  end
  always @(negedge mclk_in) if (cyc > 0) begin
    `CHK("int_n", xi, int_n)
    `CHK("rvalid", xv, rvalid)
    `CHK("rdata", xr, rdata & xm)
  end
  initial begin
    int op;
    void'($urandom(32'h4212));
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    step(1, 0, 8'hE2, 8'hFF, 4'h0, 1, 8'h03);
    step(0, 0, 8'h00, 8'h00, 4'hF, 1, 8'h03);
    step(1, 0, 8'hE1, 8'h20, 4'hF, 1, 8'h03);
    step(1, 0, 8'hE1, 8'h6A, 4'h0, 1, 8'h03);
    step(1, 0, 8'hE2, 8'h00, 4'h0, 0, 8'h03);
    step(0, 1, 8'hE2, 8'h00, 4'h0, 0, 8'h03);
    $display("test corner done");
    repeat (3000) begin
      op = $urandom % 3;
      step(op == 1, op == 2, ADDRS[$urandom % 8], 8'($urandom), 4'($urandom),
           $urandom % 8 != 0, ($urandom % 2) ? 8'h03 : 8'($urandom));
    end
    step(0, 0, 8'h00, 8'h00, 4'h0, 1, 8'h03);
    @(posedge mclk_in);
    $display("test random done");
    test_done();
  end
endmodule  // test_sensor_irq_and_ident_regs
